// ==== hdl/rsw_params.svh ====
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSW_CLK_HZ 20000000
`define RSW_TICK_NS 1000
`define RSW_TICK_CYCLES ((`RSW_TICK_NS * (`RSW_CLK_HZ / 1000000)) / 1000)
`define RSW_RP_US 200
`define RSW_WD_US 1000
`define RSW_WD2_US 8000
`define RSW_RP_TICKS ((`RSW_RP_US * 1000) / `RSW_TICK_NS)
`define RSW_WD_TICKS ((`RSW_WD_US * 1000) / `RSW_TICK_NS)
`define RSW_WD2_TICKS ((`RSW_WD2_US * 1000) / `RSW_TICK_NS)
`define RSW_EXT_MULT 128
`define RSW_SH_LL 3'h3
`define RSW_SH_LH 3'h4
`define RSW_SH_HH 3'h6

// ----------------------------------------
// Register map
// ----------------------------------------
`define RSW_A_CTRL 8'h00
`define RSW_A_STATUS 8'h04
`define RSW_A_IRQ_STAT 8'h08
`define RSW_A_IRQ_MASK 8'h0c
`define RSW_A_WD_COUNT 8'h10
`define RSW_CTRL_W 5
`define RSW_CTRL_WIN 0
`define RSW_CTRL_EXT 1
`define RSW_CTRL_CAPGND 2
`define RSW_CTRL_SELA 3
`define RSW_CTRL_SELB 4
`define RSW_CTRL_RST 5'h00
`define RSW_IRQ_W 3
`define RSW_IRQ_EARLY 0
`define RSW_IRQ_LATE 1
`define RSW_IRQ_COND 2
`define RSW_IRQ_RST 3'h0
`define RSW_RESP_OKAY 2'h0
`define RSW_RESP_SLVERR 2'h2

`endif

// ==== hdl/rsw_pkg.sv ====
package rsw_pkg;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_TIMEOUT = 2'b01,
    ST_RUN = 2'b10
  } rst_state_type;
endpackage : rsw_pkg

// ==== hdl/sync_edge.sv ====
`timescale 1ns/1ns
`default_nettype none

module sync_edge #(
  parameter logic RST_VAL = 1'b1
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Pin and results
  input wire logic d,
  output logic q,
  output logic fall,
  output logic edge_any
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Edges look only at the settled stages
  assign q = s2_r;
  assign fall = s3_r & ~s2_r;
  assign edge_any = s3_r ^ s2_r;
endmodule : sync_edge

`default_nettype wire

// ==== hdl/tick_div.sv ====
`timescale 1ns/1ns
`default_nettype none

module tick_div #(
  parameter int unsigned DIV = 20
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Enable pulse
  output logic tick
);
  localparam int CNT_W = $clog2(DIV + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);
  logic [CNT_W-1:0] cnt_r;
  wire wrap = (cnt_r == LAST);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      tick <= wrap;
    end
  end
endmodule : tick_div

`default_nettype wire

// ==== hdl/reset_supervisor_watchdog.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rsw_params.svh"

// Function
// - Reset output goes low while supply or external monitor is low or manual reset is low.
// - After all reset conditions clear, reset stays low one reset period, then releases.
// - Any watchdog fault gives a reset pulse of one reset period, exact for a late fault, up to one tick shorter for an early one.
// - Without the window, a timeout with no kick raises a fault and a reset pulse.
// - Without the window, a kick transition or an asserted reset clears the watchdog count.
// - Without the window, a grounded timing capacitor pin disables the watchdog.
// - With the window, a kick earlier than the fast period or later than the slow one resets.
// - With the window, a late fault holds reset low for one reset period, an early one for up to one tick less.
// - With the window, a falling kick edge, early or in-window, or an asserted reset clears the count.
// - With the window, the two select straps choose the ratio or disable the watchdog.
// - With the window, select a high and select b low disables the watchdog.
// - The slow-to-fast ratio is 8 for both low, 16 for b high only, 64 for both high.
// - Without the window, extended mode multiplies the basic timeout by 128.
// - With the window, kick edges are ignored while reset is asserted.
module reset_supervisor_watchdog #(
  parameter int unsigned RP_TICKS = `RSW_RP_TICKS,
  parameter int unsigned WD_TICKS = `RSW_WD_TICKS,
  parameter int unsigned WD2_TICKS = `RSW_WD2_TICKS,
  parameter int unsigned TICK_DIV = `RSW_TICK_CYCLES,
  parameter int CW = 24
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Monitors and processor pins
  input wire logic supply_low,
  input wire logic ext_mon_low,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_in,
  output logic reset_n_out,
  output logic irq,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // ----------------------------------------
  // Limits
  // ----------------------------------------
  localparam logic [CW-1:0] RP_LAST = CW'(RP_TICKS - 1);
  localparam logic [CW-1:0] WD_L = CW'(WD_TICKS);
  localparam logic [CW-1:0] WDX_L = CW'(WD_TICKS * `RSW_EXT_MULT);
  localparam logic [CW-1:0] WD2_L = CW'(WD2_TICKS);

  function automatic logic [2:0] ratio_shift(input logic a, input logic b);
    if (a && b) begin
      return `RSW_SH_HH;
    end else if (b) begin
      return `RSW_SH_LH;
    end else begin
      return `RSW_SH_LL;
    end
  endfunction : ratio_shift

  function automatic logic mapped(input logic [7:0] a);
    return a == `RSW_A_CTRL || a == `RSW_A_STATUS || a == `RSW_A_IRQ_STAT ||
           a == `RSW_A_IRQ_MASK || a == `RSW_A_WD_COUNT;
  endfunction : mapped

  // ----------------------------------------
  // Inputs
  // ----------------------------------------
  logic kick_fall;
  logic kick_any;
  logic mr_lvl;
  logic tick;

  sync_edge #(.RST_VAL(1'b1)) u_kick (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(watchdog_kick_in),
    .q(),
    .fall(kick_fall),
    .edge_any(kick_any)
  );

  sync_edge #(.RST_VAL(1'b1)) u_mr (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(manual_reset_in_n),
    .q(mr_lvl),
    .fall(),
    .edge_any()
  );

  tick_div #(.DIV(TICK_DIV)) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [`RSW_CTRL_W-1:0] ctrl_r;
  logic [`RSW_CTRL_W-1:0] ctrl_nxt;
  logic [`RSW_IRQ_W-1:0] irq_stat_r;
  logic [`RSW_IRQ_W-1:0] irq_stat_nxt;
  logic [`RSW_IRQ_W-1:0] irq_mask_r;
  logic [`RSW_IRQ_W-1:0] irq_mask_nxt;
  rsw_pkg::rst_state_type state_r;
  rsw_pkg::rst_state_type state_nxt;
  logic [CW-1:0] rp_cnt_r;
  logic [CW-1:0] rp_cnt_nxt;
  logic [CW-1:0] wd_cnt_r;
  logic [CW-1:0] wd_cnt_nxt;
  logic ext_q_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  wire windowed = ctrl_r[`RSW_CTRL_WIN];
  wire ext_sel = ctrl_r[`RSW_CTRL_EXT];
  wire cap_gnd = ctrl_r[`RSW_CTRL_CAPGND];
  wire sel_a = ctrl_r[`RSW_CTRL_SELA];
  wire sel_b = ctrl_r[`RSW_CTRL_SELB];
  wire win_off = sel_a & ~sel_b;
  wire wd_en = windowed ? ~win_off : ~cap_gnd;
  wire [CW-1:0] basic_lim = ext_sel ? WDX_L : WD_L;
  wire [CW-1:0] slow_lim = windowed ? WD2_L : basic_lim;
  wire [CW-1:0] fast_lim = WD2_L >> ratio_shift(sel_a, sel_b);
  wire running = (state_r == rsw_pkg::ST_RUN);
  wire cond = supply_low | ext_mon_low | ~mr_lvl;

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Edges outside RUN never reach the fault terms
  wire late_fault = running & wd_en & tick &
                    (wd_cnt_r >= slow_lim - 1'b1);
  wire early_fault = running & wd_en & windowed & kick_fall &
                     (wd_cnt_r < fast_lim);
  wire wd_fault = late_fault | early_fault;
  wire kick_clr = windowed ? kick_fall : kick_any;
  wire ext_tog = ext_sel ^ ext_q_r;

  // Count is held at zero until reset releases
  assign wd_cnt_nxt = (!running || wd_fault || kick_clr || ext_tog) ? '0 :
                      (tick && wd_en) ? wd_cnt_r + 1'b1 : wd_cnt_r;

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  always_comb begin
    case (state_r)
      rsw_pkg::ST_HOLD: begin
        state_nxt = cond ? rsw_pkg::ST_HOLD : rsw_pkg::ST_TIMEOUT;
      end
      rsw_pkg::ST_TIMEOUT: begin
        if (cond) begin
          state_nxt = rsw_pkg::ST_HOLD;
        end else if (tick && rp_cnt_r == RP_LAST) begin
          state_nxt = rsw_pkg::ST_RUN;
        end else begin
          state_nxt = rsw_pkg::ST_TIMEOUT;
        end
      end
      rsw_pkg::ST_RUN: begin
        if (cond) begin
          state_nxt = rsw_pkg::ST_HOLD;
        end else if (wd_fault) begin
          state_nxt = rsw_pkg::ST_TIMEOUT;
        end else begin
          state_nxt = rsw_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = rsw_pkg::ST_HOLD;
      end
    endcase
  end

  wire in_to = (state_r == rsw_pkg::ST_TIMEOUT);
  assign rp_cnt_nxt = (!in_to || state_nxt != rsw_pkg::ST_TIMEOUT) ? '0 :
                      tick ? rp_cnt_r + 1'b1 : rp_cnt_r;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire ar_hs = arvalid & arready;
  wire do_wr = aw_hold_r & w_hold_r & ~bvalid;
  wire wr_ok = do_wr & wstrb0_r;
  wire wr_ctrl = wr_ok & (waddr_r == `RSW_A_CTRL);
  wire wr_stat = wr_ok & (waddr_r == `RSW_A_IRQ_STAT);
  wire wr_mask = wr_ok & (waddr_r == `RSW_A_IRQ_MASK);

  // Set beats clear so a fault in the clearing cycle survives
  wire [`RSW_IRQ_W-1:0] irq_ev = {cond & (state_r != rsw_pkg::ST_HOLD),
                                  late_fault, early_fault};
  wire [`RSW_IRQ_W-1:0] w1c = wr_stat ? wdata_r[`RSW_IRQ_W-1:0] : '0;
  assign irq_stat_nxt = (irq_stat_r & ~w1c) | irq_ev;
  assign irq_mask_nxt = wr_mask ? wdata_r[`RSW_IRQ_W-1:0] : irq_mask_r;
  assign ctrl_nxt = wr_ctrl ? wdata_r[`RSW_CTRL_W-1:0] : ctrl_r;

  wire [31:0] rd_mux =
    (araddr == `RSW_A_CTRL) ? 32'(ctrl_r) :
    (araddr == `RSW_A_STATUS) ? {27'h0, wd_en, cond, state_r, reset_n_out} :
    (araddr == `RSW_A_IRQ_STAT) ? 32'(irq_stat_r) :
    (araddr == `RSW_A_IRQ_MASK) ? 32'(irq_mask_r) :
    (araddr == `RSW_A_WD_COUNT) ? 32'(wd_cnt_r) : 32'h0;

  // ----------------------------------------
  // Flops
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= rsw_pkg::ST_HOLD;
      rp_cnt_r <= '0;
      wd_cnt_r <= '0;
      ctrl_r <= `RSW_CTRL_RST;
      ext_q_r <= 1'b0;
      irq_stat_r <= `RSW_IRQ_RST;
      irq_mask_r <= `RSW_IRQ_RST;
      reset_n_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rp_cnt_r <= rp_cnt_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      ctrl_r <= ctrl_nxt;
      ext_q_r <= ext_sel;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      reset_n_out <= (state_nxt == rsw_pkg::ST_RUN);
      irq <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // One write in flight; both channels reopen after the response
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RSW_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_hold_r <= 1'b1;
        waddr_r <= awaddr;
        awready <= 1'b0;
      end
      if (w_hs) begin
        w_hold_r <= 1'b1;
        wdata_r <= wdata;
        wstrb0_r <= wstrb[0];
        wready <= 1'b0;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(waddr_r) ? `RSW_RESP_OKAY : `RSW_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RSW_RESP_OKAY;
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= mapped(araddr) ? `RSW_RESP_OKAY : `RSW_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence pulse_start_s;
    !reset_n_out && rp_cnt_r == '0 && state_r == rsw_pkg::ST_TIMEOUT;
  endsequence
  sequence pulse_hold_s;
    !reset_n_out [*2];
  endsequence

  cond_asserts_a: assert property (cond |=> !reset_n_out)
    else $error("reset output high while a reset condition held");
  release_rp_a: assert property ($rose(reset_n_out) |->
      $past(rp_cnt_r) == RP_LAST && !$past(cond) && $past(tick))
    else $error("reset released before the reset period ran out");
  fault_pulse_a: assert property (wd_fault && !cond |=>
      pulse_start_s ##0 pulse_hold_s)
    else $error("watchdog fault did not start a reset pulse");
  late_limit_a: assert property (late_fault && !windowed |->
      wd_cnt_r >= basic_lim - 1'b1 && tick)
    else $error("timeout fault before the timeout count");
  clear_rst_a: assert property (!running |=> wd_cnt_r == '0)
    else $error("watchdog count moved while reset asserted");
  cap_off_a: assert property (!windowed && cap_gnd |-> !wd_fault)
    else $error("watchdog fault with timing pin grounded");
  early_kick_a: assert property (running && windowed && wd_en && kick_fall
      && wd_cnt_r < (WD2_L >> ratio_shift(sel_a, sel_b)) |=>
      !reset_n_out)
    else $error("early kick did not assert reset");
  strap_off_a: assert property (windowed && sel_a && !sel_b |->
      !wd_fault)
    else $error("watchdog fault while straps disable it");
  kick_ignored_a: assert property (windowed && !running && kick_fall |->
      !early_fault)
    else $error("kick edge acted on while reset asserted");
endmodule : reset_supervisor_watchdog

`default_nettype wire

// ==== sim/host_cpu_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module host_cpu_model (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Supervisor side
  input wire logic rst_n,
  input wire logic en,
  input wire logic [15:0] period,
  output logic kick
);
  logic [15:0] cnt_r;

  // ----------------------------------------
  // Kick pulses
  // ----------------------------------------
  // Loop restarts on reset release, so the first falling edge is period - 2
  // clocks after release and the window phase is known
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 16'h0000;
      kick <= 1'b1;
    end else if (!rst_n || !en) begin
      cnt_r <= 16'h0000;
      kick <= 1'b1;
    end else begin
      cnt_r <= (cnt_r >= period - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
      kick <= (cnt_r < period - 16'h0003);
    end
  end
endmodule : host_cpu_model

`default_nettype wire

// ==== sim/reset_supervisor_watchdog_test.sv ====
`timescale 1ns/1ns
`default_nettype none

module reset_supervisor_watchdog_test;
  localparam int TD = 2;
  localparam int RPT = 4;
  localparam int WDT = 8;
  localparam int W2T = 128;
  localparam int RPC = RPT * TD;
  localparam int WDC = WDT * TD;
  localparam int W2C = W2T * TD;
  localparam int EXC = WDC * 128;
  localparam int QUIET = 400;
  logic clk, sys_rst, supply_low, ext_mon_low, manual_reset_in_n;
  logic watchdog_kick_in, reset_n_out, irq, en;
  logic [15:0] per;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, a, b;
  int compares, fail_count, n, i;
  integer seed;

  reset_supervisor_watchdog #(.RP_TICKS(RPT), .WD_TICKS(WDT),
    .WD2_TICKS(W2T), .TICK_DIV(TD)) DUT (.*);
  host_cpu_model host (.clk(clk), .sys_rst(sys_rst), .rst_n(reset_n_out),
    .en(en), .period(per), .kick(watchdog_kick_in));

  always #25 clk = ~clk;

  // ----------------------------------------
  // Checking and expectations
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  function automatic logic near(int v, int nom, int lo, int hi);
    return v >= nom - lo && v <= nom + hi;
  endfunction : near

  // Fast window in clocks is the slow one divided by the strap ratio
  function automatic logic exp_early(logic sa, logic sb, int p);
    int f;
    f = W2C >> (sb ? (sa ? 6 : 4) : 3);
    return p < f;
  endfunction : exp_early

  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] v,
                    output logic [1:0] rs);
    int k;
    @(posedge clk);
    awaddr <= ad;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rs = bresp;
    if (k == 100) begin
      fail_count++;
      conclude();
    end
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [31:0] v,
                    output logic [1:0] rs);
    int k;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    v = rdata;
    rs = rresp;
    if (k == 100) begin
      fail_count++;
      conclude();
    end
  endtask : rd

  // A bound that runs out is a valid outcome here: quiet periods use it
  task automatic wait_lvl(input logic lvl, input int bound, output int m);
    for (m = 0; m < bound && reset_n_out !== lvl; m++) @(posedge clk);
  endtask : wait_lvl

  task automatic bump();
    @(posedge clk);
    supply_low <= 1'b1;
    repeat (4) @(posedge clk);
    supply_low <= 1'b0;
    wait_lvl(1'b1, 100, n);
    check(n < 100, 1'b1);
  endtask : bump

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hc8203e95;
    clk = 1'b0;
    sys_rst = 1'b1;
    {supply_low, ext_mon_low, manual_reset_in_n, en} = 4'h3;
    per = 16'h0008;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, d, r);
    check(d, 32'h0);
    rd(8'h0c, d, r);
    check(d, 32'h0);
    rd(8'h14, d, r);
    check({d[29:0], r}, 32'h2);
    wr(8'h14, 32'hffffffff, r);
    check(r, 2'h2);
    wait_lvl(1'b1, 200, n);
    check(n < 200, 1'b1);
    // Status: enabled, no condition, running, reset released
    rd(8'h04, d, r);
    check(d, 32'h15);
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      supply_low <= (i == 0);
      ext_mon_low <= (i == 1);
      manual_reset_in_n <= (i != 2);
      repeat (6 + ($random(seed) & 15)) @(posedge clk);
      check(reset_n_out, 1'b0);
      supply_low <= 1'b0;
      ext_mon_low <= 1'b0;
      manual_reset_in_n <= 1'b1;
      wait_lvl(1'b1, 200, n);
      check(near(n, RPC, 2, 8), 1'b1);
    end
    rd(8'h08, d, r);
    check(d, 32'h4);
    check(irq, 1'b0);
    wr(8'h0c, 32'h4, r);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    wr(8'h08, 32'h4, r);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    per <= 16'h0004 + 16'(($random(seed) & 7));
    wait_lvl(1'b0, QUIET, n);
    check(n, QUIET);
    en <= 1'b0;
    // Let the last kick transition clear the count before timing starts
    repeat (4) @(posedge clk);
    wait_lvl(1'b0, 100, n);
    check(near(n, WDC, 10, 4), 1'b1);
    wait_lvl(1'b1, 100, n);
    check(near(n, RPC, 2, 2), 1'b1);
    en <= 1'b1;
    rd(8'h08, d, r);
    check(d, 32'h2);
    en <= 1'b0;
    wr(8'h00, 32'h2, r);
    wait_lvl(1'b0, EXC + 100, n);
    check(near(n, EXC, 12, 4), 1'b1);
    wait_lvl(1'b1, 100, n);
    wr(8'h00, 32'h4, r);
    wait_lvl(1'b0, QUIET, n);
    check(n, QUIET);
    en <= 1'b1;
    per <= 16'h0018;
    wr(8'h08, 32'h7, r);
    for (i = 0; i < 3; i++) begin
      a = (i == 2);
      b = (i > 0);
      wr(8'h00, {27'h0, b, a, 3'h1}, r);
      bump();
      wait_lvl(1'b0, QUIET, n);
      check(n < QUIET, exp_early(a, b, 24));
    end
    en <= 1'b0;
    bump();
    wait_lvl(1'b0, QUIET, n);
    check(near(n, W2C, 6, 4), 1'b1);
    wait_lvl(1'b1, 100, n);
    check(near(n, RPC, 2, 2), 1'b1);
    rd(8'h08, d, r);
    check({30'h0, d[1:0]}, 32'h3);
    wr(8'h00, 32'h9, r);
    bump();
    wait_lvl(1'b0, QUIET, n);
    check(n, QUIET);
    conclude();
  end
endmodule : reset_supervisor_watchdog_test

`default_nettype wire
